//--- bps_far_end.sv
`timescale 1ns/100ps

// ==========================================
// far side: request bits become event strobes
// ==========================================
module bps_far_end (
    input  wire logic        core_clk,
    input  wire logic [14:0] fire,
    output logic      [14:0] ev
);
    // one cycle late, as a link decoder would report it
    always_ff @(posedge core_clk) begin
        ev <= fire;
    end
endmodule : bps_far_end

//--- bps_pkg.sv
package bps_pkg;

    // ========================================================
    // register map, byte addresses on the AHB-Lite side
    // ========================================================
    localparam logic [7:0] CFG_OFS      = 8'h04;
    localparam logic [7:0] MASK_OFS     = 8'h40;
    localparam logic [2:0] HSIZE_WORD   = 3'h2;
    localparam logic [1:0] HTRANS_NSEQ  = 2'h2;

    // ========================================================
    // field positions within the configuration word
    // ========================================================
    localparam int PERR_EN_BIT  = 6;
    localparam int CAP_BIT      = 20;
    localparam int MHZ66_BIT    = 21;
    localparam int FBB_BIT      = 23;
    localparam int MDPE_BIT     = 24;
    localparam int DEVSEL_LSB   = 25;
    localparam int DEVSEL_MSB   = 26;
    localparam int STA_BIT      = 27;
    localparam int DPE_BIT      = 31;

    // flag vector index, low to high: mdpe sta rta rma sse dpe
    localparam int NFLAG  = 6;
    localparam int F_MDPE = 0;
    localparam int F_STA  = 1;
    localparam int F_RTA  = 2;
    localparam int F_RMA  = 3;
    localparam int F_SSE  = 4;
    localparam int F_DPE  = 5;

    // ========================================================
    // codes and reset values
    // ========================================================
    localparam logic [1:0]       DEVSEL_FAST   = 2'h0;
    localparam logic [1:0]       DEVSEL_MEDIUM = 2'h1;
    localparam logic [NFLAG-1:0] FLAG_RST      = 6'h00;
    localparam logic [NFLAG-1:0] MASK_RST      = 6'h00;
    localparam logic             PERR_EN_RST   = 1'b0;
    localparam logic [31:0]      WORD_ZERO     = 32'h0000_0000;

endpackage : bps_pkg

//--- bps_primary_status.sv
`timescale 1ns/100ps

module bps_primary_status
    import bps_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             irq,
    output logic             perr_resp_en,
    input  wire logic        reverse_strap,
    input  wire logic        conv_pci_primary,
    input  wire logic        fwd_poisoned_cpl_rx,
    input  wire logic        fwd_poisoned_wr_tx,
    input  wire logic        rev_read_perr,
    input  wire logic        rev_parity_error_pin_on_write,
    input  wire logic        rev_split_msg_perr,
    input  wire logic        fwd_ca_cpl_sent,
    input  wire logic        rev_target_abort_sent,
    input  wire logic        fwd_ca_cpl_rx,
    input  wire logic        rev_target_abort_rx,
    input  wire logic        fwd_ur_cpl_rx,
    input  wire logic        rev_master_abort,
    input  wire logic        fwd_err_msg_sent,
    input  wire logic        rev_serr_driven,
    input  wire logic        fwd_poisoned_tlp,
    input  wire logic        rev_parity_err_det
);
    import bps_pkg::*;

    // ========================================================
    // state
    // ========================================================
    logic             reverse_reg;
    logic             conv_reg;
    logic             perr_en_reg;
    logic             perr_en_next;
    logic [NFLAG-1:0] flag_reg;
    logic [NFLAG-1:0] flag_next;
    logic [NFLAG-1:0] mask_reg;
    logic [NFLAG-1:0] mask_next;
    logic             wr_pend_reg;
    logic [7:0]       addr_reg;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;
    logic             irq_reg;

    // ========================================================
    // AHB-Lite decode
    // ========================================================
    wire        addr_take  = hsel & hready & htrans[1];
    wire        word_ok    = (hsize == HSIZE_WORD);
    wire        wr_take    = addr_take & hwrite & word_ok;
    wire        rd_take    = addr_take & ~hwrite;
    wire        wr_cfg     = wr_pend_reg & (addr_reg == CFG_OFS);
    wire        wr_mask    = wr_pend_reg & (addr_reg == MASK_OFS);
    wire [7:0]  addr_lo    = haddr[7:0];
    wire [NFLAG-1:0] wdata_flags = {hwdata[DPE_BIT:STA_BIT], hwdata[MDPE_BIT]};
    wire [NFLAG-1:0] clr   = wr_cfg ? wdata_flags : '0;

    // ========================================================
    // event steering by strapped mode
    // ========================================================
    wire fwd = ~reverse_reg;
    wire rev = reverse_reg;
    wire [NFLAG-1:0] set;

    // gated by parity response enable
    assign set[F_MDPE] = perr_en_reg & (
                         (fwd & (fwd_poisoned_cpl_rx | fwd_poisoned_wr_tx)) |
                         (rev & (rev_read_perr
                                 | rev_parity_error_pin_on_write
                                 | rev_split_msg_perr)));
    assign set[F_STA]  = (fwd & fwd_ca_cpl_sent)
                       | (rev & rev_target_abort_sent);
    assign set[F_RTA]  = (fwd & fwd_ca_cpl_rx)
                       | (rev & rev_target_abort_rx);
    assign set[F_RMA]  = (fwd & fwd_ur_cpl_rx)
                       | (rev & rev_master_abort);
    assign set[F_SSE]  = (fwd & fwd_err_msg_sent)
                       | (rev & rev_serr_driven);
    // detected parity ignores the response enable
    assign set[F_DPE]  = (fwd & fwd_poisoned_tlp)
                       | (rev & rev_parity_err_det);

    // ========================================================
    // sticky flags: a set in the clearing cycle wins
    // ========================================================
    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_flag
            assign flag_next[gi] = (flag_reg[gi] & ~clr[gi]) | set[gi];
        end
    endgenerate

    assign perr_en_next = wr_cfg ? hwdata[PERR_EN_BIT] : perr_en_reg;
    assign mask_next    = wr_mask ? wdata_flags : mask_reg;

    // ========================================================
    // status half-word layout
    // ========================================================
    wire [1:0]  devsel   = rev ? DEVSEL_MEDIUM : DEVSEL_FAST;
    wire        mhz66    = rev;
    wire        fbb      = rev & conv_reg;

    // mode bits are arguments: a continuous assign only wakes on its operands
    function automatic logic [31:0] cfg_word(input logic [NFLAG-1:0] f,
                                             input logic             pe,
                                             input logic             m66,
                                             input logic             fb,
                                             input logic [1:0]       ds);
        logic [31:0] w;
        w                         = WORD_ZERO;
        w[PERR_EN_BIT]            = pe;
        w[CAP_BIT]                = 1'b1;
        w[MHZ66_BIT]              = m66;
        w[FBB_BIT]                = fb;
        w[MDPE_BIT]               = f[F_MDPE];
        w[DEVSEL_MSB:DEVSEL_LSB]  = ds;
        w[DPE_BIT:STA_BIT]        = f[F_DPE:F_STA];
        return w;
    endfunction : cfg_word

    wire [31:0] cfg_rd   = cfg_word(flag_next, perr_en_next, mhz66, fbb, devsel);
    wire [31:0] mask_rd  = {mask_next[F_DPE:F_STA], 2'b00,
                            mask_next[F_MDPE], 24'h00_0000};

    // read data sampled from next-state so a read right after a write sees it
    assign rdata_next = !rd_take                ? rdata_reg :
                        (addr_lo == CFG_OFS)    ? cfg_rd    :
                        (addr_lo == MASK_OFS)   ? mask_rd   : WORD_ZERO;

    // ========================================================
    // registers
    // ========================================================
    always_ff @(posedge core_clk) begin
        if (rst) begin
            // strap levels are caught while reset is held
            reverse_reg <= reverse_strap;
            conv_reg    <= conv_pci_primary;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            perr_en_reg <= PERR_EN_RST;
            flag_reg    <= FLAG_RST;
            mask_reg    <= MASK_RST;
            irq_reg     <= 1'b0;
        end else begin
            perr_en_reg <= perr_en_next;
            flag_reg    <= flag_next;
            mask_reg    <= mask_next;
            irq_reg     <= |(flag_next & mask_next);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            rdata_reg   <= WORD_ZERO;
        end else begin
            wr_pend_reg <= wr_take;
            addr_reg    <= addr_take ? addr_lo : addr_reg;
            rdata_reg   <= rdata_next;
        end
    end

    // zero wait states, never an error response
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = rdata_reg;
    assign irq          = irq_reg;
    assign perr_resp_en = perr_en_reg;

    // ========================================================
    // checks
    // ========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    wire [31:0] st_word = cfg_word(flag_reg, perr_en_reg, mhz66, fbb, devsel);
    wire [15:0] st_now  = st_word[31:16];

    property p_cap_one;
        rd_take && addr_lo == CFG_OFS |=> hrdata[CAP_BIT];
    endproperty
    a_cap_one: assert property (p_cap_one)
        else $error("capability bit not one");

    property p_mhz66;
        rd_take && addr_lo == CFG_OFS |=> hrdata[MHZ66_BIT] == reverse_reg;
    endproperty
    a_mhz66: assert property (p_mhz66)
        else $error("66 MHz bit wrong for mode");

    property p_fbb;
        rd_take && addr_lo == CFG_OFS
            |=> hrdata[FBB_BIT] == (reverse_reg && conv_reg);
    endproperty
    a_fbb: assert property (p_fbb)
        else $error("fast back-to-back bit wrong");

    property p_mdpe_gate;
        $rose(flag_reg[F_MDPE]) |-> $past(perr_en_reg);
    endproperty
    a_mdpe_gate: assert property (p_mdpe_gate)
        else $error("parity flag set while response disabled");

    property p_mdpe_rev;
        rev && perr_en_reg && (rev_read_perr || rev_split_msg_perr
            || rev_parity_error_pin_on_write) |=> flag_reg[F_MDPE];
    endproperty
    a_mdpe_rev: assert property (p_mdpe_rev)
        else $error("reverse parity case missed");

    property p_devsel;
        rd_take && addr_lo == CFG_OFS
            |=> hrdata[DEVSEL_MSB:DEVSEL_LSB] == (reverse_reg ? 2'h1 : 2'h0);
    endproperty
    a_devsel: assert property (p_devsel)
        else $error("devsel timing code wrong");

    property p_sta_fwd;
        fwd && fwd_ca_cpl_sent |=> flag_reg[F_STA];
    endproperty
    a_sta_fwd: assert property (p_sta_fwd)
        else $error("signalled abort not set");

    property p_rma_rev;
        rev && rev_master_abort ##1 !wr_cfg[*2] |-> flag_reg[F_RMA];
    endproperty
    a_rma_rev: assert property (p_rma_rev)
        else $error("master abort flag lost");

    property p_dpe_fwd;
        fwd && !perr_en_reg && fwd_poisoned_tlp |=> flag_reg[F_DPE];
    endproperty
    a_dpe_fwd: assert property (p_dpe_fwd)
        else $error("poisoned TLP not flagged");

    property p_perr_rst;
        disable iff (1'b0)
        rst |=> !perr_en_reg;
    endproperty
    a_perr_rst: assert property (p_perr_rst)
        else $error("parity enable not cleared by reset");

    property p_sticky;
        flag_reg[F_SSE] && !(wr_cfg && hwdata[DPE_BIT - 1]) |=> flag_reg[F_SSE];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without write one");

    property p_reserved;
        st_now[3:0] == 4'h0 && st_now[6] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits nonzero");

    property p_irq;
        (flag_reg & mask_reg) != '0 |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq low with unmasked flag");

    property p_irq_low;
        (flag_reg & mask_reg) == '0 |-> !irq;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("irq high with no unmasked flag");

    property p_mdpe_fwd;
        fwd && perr_en_reg && (fwd_poisoned_cpl_rx || fwd_poisoned_wr_tx)
            |=> flag_reg[F_MDPE];
    endproperty
    a_mdpe_fwd: assert property (p_mdpe_fwd)
        else $error("forward poison case missed");

    property p_sta_rev;
        rev && rev_target_abort_sent |=> flag_reg[F_STA];
    endproperty
    a_sta_rev: assert property (p_sta_rev)
        else $error("reverse signalled abort not set");

    property p_rta_fwd;
        fwd && fwd_ca_cpl_rx |=> flag_reg[F_RTA];
    endproperty
    a_rta_fwd: assert property (p_rta_fwd)
        else $error("forward received abort not set");

    property p_rta_rev;
        rev && rev_target_abort_rx |=> flag_reg[F_RTA];
    endproperty
    a_rta_rev: assert property (p_rta_rev)
        else $error("reverse received abort not set");

    property p_rma_fwd;
        fwd && fwd_ur_cpl_rx |=> flag_reg[F_RMA];
    endproperty
    a_rma_fwd: assert property (p_rma_fwd)
        else $error("unsupported request not flagged");

    property p_sse_fwd;
        fwd && fwd_err_msg_sent |=> flag_reg[F_SSE];
    endproperty
    a_sse_fwd: assert property (p_sse_fwd)
        else $error("error message not flagged");

    property p_sse_rev;
        rev && rev_serr_driven |=> flag_reg[F_SSE];
    endproperty
    a_sse_rev: assert property (p_sse_rev)
        else $error("system error drive not flagged");

    property p_dpe_rev;
        rev && rev_parity_err_det |=> flag_reg[F_DPE];
    endproperty
    a_dpe_rev: assert property (p_dpe_rev)
        else $error("reverse parity error not flagged");

    property p_perr_wr;
        wr_cfg |=> perr_en_reg == $past(hwdata[PERR_EN_BIT]);
    endproperty
    a_perr_wr: assert property (p_perr_wr)
        else $error("parity enable not written");

    property p_clear;
        wr_cfg && hwdata[STA_BIT] && !set[F_STA] |=> !flag_reg[F_STA];
    endproperty
    a_clear: assert property (p_clear)
        else $error("write one did not clear flag");

    property p_sticky_sta;
        flag_reg[F_STA] && !(wr_cfg && hwdata[STA_BIT]) |=> flag_reg[F_STA];
    endproperty
    a_sticky_sta: assert property (p_sticky_sta)
        else $error("abort flag dropped without write one");

    property p_unmapped;
        rd_take && addr_lo != CFG_OFS && addr_lo != MASK_OFS |=> hrdata == WORD_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_mask_rd;
        rd_take && addr_lo == MASK_OFS |=> hrdata[23:0] == 24'h00_0000;
    endproperty
    a_mask_rd: assert property (p_mask_rd)
        else $error("mask low bits not zero");

endmodule : bps_primary_status

//--- test_bridge_primary_status.sv
`timescale 1ns/100ps

module test_bridge_primary_status;
    import bps_pkg::*;
    // ==========================================
    // signals
    // ==========================================
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        hsel     = 1'b0;
    logic        hwrite   = 1'b0;
    logic        rev      = 1'b0;
    logic        conv     = 1'b0;
    logic [31:0] haddr    = 32'h0000_0000;
    logic [31:0] hwdata   = 32'h0000_0000;
    logic [1:0]  htrans   = 2'h0;
    logic [2:0]  hsize    = 3'h0;
    logic [14:0] fire     = 15'h0000;
    logic [14:0] ev;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        perr_resp_en;
    int          error_cnt = 0;
    int          compares  = 0;
    int          cyc       = 0;
    // flag bit per strobe, and which strobes belong to forward mode
    localparam int          FLAG_OF [15] = '{24, 24, 24, 24, 24, 27, 27, 28, 28, 29, 29, 30, 30, 31, 31};
    localparam logic [14:0] FWD_SET      = 15'h2aa3;

    always #10 core_clk = ~core_clk;

    bps_far_end far (.core_clk(core_clk), .fire(fire), .ev(ev));

    bps_primary_status uut (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
        .perr_resp_en(perr_resp_en), .reverse_strap(rev), .conv_pci_primary(conv),
        .fwd_poisoned_cpl_rx(ev[0]), .fwd_poisoned_wr_tx(ev[1]), .rev_read_perr(ev[2]),
        .rev_parity_error_pin_on_write(ev[3]), .rev_split_msg_perr(ev[4]),
        .fwd_ca_cpl_sent(ev[5]), .rev_target_abort_sent(ev[6]), .fwd_ca_cpl_rx(ev[7]),
        .rev_target_abort_rx(ev[8]), .fwd_ur_cpl_rx(ev[9]), .rev_master_abort(ev[10]),
        .fwd_err_msg_sent(ev[11]), .rev_serr_driven(ev[12]), .fwd_poisoned_tlp(ev[13]),
        .rev_parity_err_det(ev[14])
    );

    // ==========================================
    // helpers
    // ==========================================
    task results;
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // a hang anywhere ends here rather than spinning forever
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results;
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // no wait limit here: the cycle ceiling ends a hang
    task wait_rdy;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge core_clk);
        end
    endtask : wait_rdy

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= HTRANS_NSEQ;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask : bus

    task rst_dut(input logic r, input logic c);
        rst  <= 1'b1;
        rev  <= r;
        conv <= c;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
    endtask : rst_dut

    // strobe lands in the flag two edges after the request
    task pulse(input int i);
        fire <= 15'h0001 << i;
        @(posedge core_clk);
        fire <= 15'h0000;
        repeat (2) @(posedge core_clk);
    endtask : pulse

    function logic [31:0] base_word;
        base_word = 32'h0010_0000 | (rev ? 32'h0220_0000 : 32'h0000_0000);
        if (rev && conv) base_word = base_word | 32'h0080_0000;
    endfunction : base_word

    // ==========================================
    // scenarios
    // ==========================================
    task t_reset_vals;
        bus(1'b0, CFG_OFS, WORD_ZERO);
        chk("status", base_word(), rd);
        chk("perr_en", 32'h0000_0000, 32'(perr_resp_en));
        bus(1'b0, MASK_OFS, WORD_ZERO);
        chk("mask", 32'h0000_0000, rd);
        chk("irq", 32'h0000_0000, 32'(irq));
    endtask : t_reset_vals

    task t_events;
        logic [31:0] f;
        bus(1'b1, CFG_OFS, 32'h0000_0040);
        // the enable register updates at the edge that ends the write
        @(posedge core_clk);
        chk("perr_en", 32'h0000_0001, 32'(perr_resp_en));
        for (int i = 0; i < 15; i++) begin
            f = (FWD_SET[i] ^ rev) ? (32'h1 << FLAG_OF[i]) : 32'h0;
            pulse(i);
            bus(1'b0, CFG_OFS, WORD_ZERO);
            chk("flag", base_word() | 32'h40 | f, rd);
            bus(1'b1, CFG_OFS, 32'h0000_0040);
            bus(1'b0, CFG_OFS, WORD_ZERO);
            chk("kept", base_word() | 32'h40 | f, rd);
            bus(1'b1, CFG_OFS, 32'h40 | f);
            bus(1'b0, CFG_OFS, WORD_ZERO);
            chk("cleared", base_word() | 32'h40, rd);
        end
    endtask : t_events

    // parity response off: bit 24 stays clear, bit 31 still sets
    task t_gate;
        bus(1'b1, CFG_OFS, WORD_ZERO);
        @(posedge core_clk);
        chk("perr_en", 32'h0000_0000, 32'(perr_resp_en));
        pulse(rev ? 2 : 0);
        pulse(rev ? 14 : 13);
        bus(1'b0, CFG_OFS, WORD_ZERO);
        chk("gated", base_word() | 32'h8000_0000, rd);
        bus(1'b1, CFG_OFS, 32'h8000_0000);
    endtask : t_gate

    task t_irq;
        bus(1'b1, MASK_OFS, 32'h1000_0000);
        pulse(rev ? 8 : 7);
        pulse(rev ? 10 : 9);
        bus(1'b0, MASK_OFS, WORD_ZERO);
        chk("mask", 32'h1000_0000, rd);
        chk("irq", 32'h0000_0001, 32'(irq));
        bus(1'b1, CFG_OFS, 32'h1000_0000);
        bus(1'b0, CFG_OFS, WORD_ZERO);
        chk("irq", 32'h0000_0000, 32'(irq));
        chk("other", base_word() | 32'h2000_0000, rd);
        bus(1'b1, CFG_OFS, 32'hffff_ffff);
        bus(1'b0, CFG_OFS, WORD_ZERO);
        chk("ro_bits", base_word() | 32'h40, rd);
        bus(1'b1, CFG_OFS, WORD_ZERO);
        bus(1'b0, 8'h80, WORD_ZERO);
        chk("unmapped", 32'h0000_0000, rd);
        chk("hresp", 32'h0000_0000, 32'(hresp));
        chk("hreadyout", 32'h0000_0001, 32'(hreadyout));
    endtask : t_irq

    initial begin
        rst_dut(1'b0, 1'b0);
        t_reset_vals;
        t_events;
        t_gate;
        t_irq;
        rst_dut(1'b1, 1'b1);
        t_reset_vals;
        t_events;
        t_gate;
        t_irq;
        rst_dut(1'b1, 1'b0);
        t_reset_vals;
        results;
    end
endmodule : test_bridge_primary_status
